// file: hdl/acs_sequencer.sv
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - conversion is 4 sample cycles then 12 convert cycles, 16 in total.
// - conversion runs in hardware with no further bus activity needed.
// - start bit written high then low starts one conversion.
// - busy flag is high during conversion and low once it completes.
// - after busy falls the result is readable in two byte registers.
// - interrupt line needs both global and converter enables set.
// - power enable low switches converter off; software sets it before use.
// - external source routes the channel chosen by channel select.
// - internal source disconnects every external channel.
// - result format bit arranges the 12 bits across both bytes.
// - reference select, amplifier input and gain come from software.
// - result is a 12-bit unsigned code, full scale FFF hex.
// - one code step is reference over 4096.
// - completion sets interrupt flag; a successful start sets busy.
// - conversion clock is system clock divided by 1 up to 128.
module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic        hclk,                 // system clock
    input  wire logic        hresetn,              // async reset, low
    input  wire logic        hsel,                 // slave select
    input  wire logic [31:0] haddr,                // byte address
    input  wire logic [1:0]  htrans,               // transfer type
    input  wire logic        hwrite,               // write when high
    input  wire logic [2:0]  hsize,                // transfer size
    input  wire logic [31:0] hwdata,               // write data
    input  wire logic        hready,               // bus ready
    output logic [31:0]      hrdata,               // read data
    output logic             hreadyout,            // slave ready
    output logic             hresp,                // response, always okay
    input  wire logic [11:0] core_code,            // code from analog core
    output logic             core_power_on,        // analog power
    output logic             core_sample,          // sampling phase
    output logic             core_convert,         // conversion phase
    output logic             core_conv_clk,        // conversion clock tick
    output logic             ext_channel_connect,  // external channel routed
    output logic [3:0]       ext_channel_out,      // routed channel number
    output logic [3:0]       input_source_out,     // input source code
    output logic [1:0]       reference_source_out, // reference select
    output logic [2:0]       pga_gain_out,         // amplifier gain
    output logic [1:0]       pga_input_out,        // amplifier input
    output logic             irq                   // level interrupt
);
    // register state
    logic [7:0]    ctrl0_r;
    logic [7:0]    ctrl0_nxt;
    logic [14:0]   ctrl1_r;
    logic [14:0]   ctrl1_nxt;
    logic [11:0]   result_r;
    logic [11:0]   result_nxt;
    logic          irq_st_r;
    logic          irq_st_nxt;
    logic          irq_msk_r;
    logic          irq_msk_nxt;
    logic          irq_glb_r;
    logic          irq_glb_nxt;
    logic          start_seen_r;
    logic          start_seen_nxt;
    logic          busy_r;
    logic          busy_nxt;
    logic [3:0]    phase_cnt_r;
    logic [3:0]    phase_cnt_nxt;
    acs_state_type state_r;
    acs_state_type state_nxt;
    // bus pipeline
    logic          wr_pend_r;
    logic [7:0]    wr_addr_r;
    logic [31:0]   rdata_r;
    logic [31:0]   rdata_nxt;

    // decoded bus wires
    wire           addr_phase = hsel && htrans[1] && hready;
    wire           rd_take    = addr_phase && !hwrite;
    wire           wr_ctrl0   = wr_pend_r && (wr_addr_r == ADDR_CTRL0);
    wire           wr_ctrl1   = wr_pend_r && (wr_addr_r == ADDR_CTRL1);
    wire           wr_irq_st  = wr_pend_r && (wr_addr_r == ADDR_IRQ_ST);
    wire           wr_irq_msk = wr_pend_r && (wr_addr_r == ADDR_IRQ_MSK);
    wire           wr_irq_glb = wr_pend_r && (wr_addr_r == ADDR_IRQ_GLB);
    wire [7:0]     rd_addr    = haddr[7:0];

    // control fields
    wire           start_bit  = ctrl0_r[C0_START];
    wire           power_en   = ctrl0_r[C0_POWER];
    wire           format_sel = ctrl0_r[C0_FORMAT];
    wire [3:0]     chan_sel   = ctrl0_r[C0_CHAN_HI:C0_CHAN_LO];
    wire [2:0]     div_sel    = ctrl1_r[C1_DIV_HI:C1_DIV_LO];
    wire [3:0]     src_sel    = ctrl1_r[C1_SRC_HI:C1_SRC_LO];

    // conversion clock enable
    logic          conv_tick;

    acs_clk_div #(
        .SEL_W (3),
        .CNT_W (7)
    ) u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (power_en),
        .div_sel (div_sel),
        .tick    (conv_tick)
    );

    // start pulse: high seen, then low completes the request
    wire           start_fall = start_seen_r && !start_bit;
    // conversion ends on the last tick of the convert phase
    wire           conv_done  = (state_r == ST_CONVERT) && conv_tick
                                && (phase_cnt_r == LAST_CONV);

    // input routing: external codes are 0000, 0100 and 11xx
    wire           src_is_ext = (src_sel == 4'h0) || (src_sel == 4'h4)
                                || (src_sel[3:2] == 2'b11);
    assign ext_channel_connect = src_is_ext && (chan_sel <= EXT_CHAN_MAX)
                                 && power_en;
    assign ext_channel_out     = ext_channel_connect ? chan_sel : 4'h0;
    assign input_source_out    = src_sel;
    assign reference_source_out = ctrl1_r[C1_REF_HI:C1_REF_LO];
    assign pga_gain_out        = ctrl1_r[C1_GAIN_HI:C1_GAIN_LO];
    assign pga_input_out       = ctrl1_r[C1_PGA_HI:C1_PGA_LO];

    // analog core strobes
    assign core_power_on = power_en;
    assign core_sample   = (state_r == ST_SAMPLE);
    assign core_convert  = (state_r == ST_CONVERT);
    assign core_conv_clk = conv_tick;

    // result byte arrangement by format bit
    wire [7:0]     res_hi = format_sel ? {4'h0, result_r[11:8]}
                                       : result_r[11:4];
    wire [7:0]     res_lo = format_sel ? result_r[7:0]
                                       : {result_r[3:0], 4'h0};

    // bus outputs; every transfer completes at once with okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    // interrupt needs the flag, its mask and the global enable
    assign irq = irq_st_r && irq_msk_r && irq_glb_r;

    // sequencer next state
    always_comb begin
        state_nxt     = state_r;
        phase_cnt_nxt = phase_cnt_r;
        busy_nxt      = busy_r;
        case (state_r)
            ST_IDLE: begin
                if (start_fall && power_en) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (conv_tick) begin
                    state_nxt     = ST_SAMPLE;
                    phase_cnt_nxt = 4'h0;
                    busy_nxt      = 1'b1;
                end
            end
            ST_SAMPLE: begin
                if (conv_tick) begin
                    phase_cnt_nxt = phase_cnt_r + 4'h1;
                    if (phase_cnt_r == LAST_SAMPLE) begin
                        state_nxt = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                if (conv_tick) begin
                    phase_cnt_nxt = phase_cnt_r + 4'h1;
                    if (phase_cnt_r == LAST_CONV) begin
                        state_nxt     = ST_IDLE;
                        phase_cnt_nxt = 4'h0;
                        busy_nxt      = 1'b0;
                    end
                end
            end
            default: begin
                state_nxt     = ST_IDLE;
                phase_cnt_nxt = 4'h0;
                busy_nxt      = 1'b0;
            end
        endcase
        // power off or a new start high abandons the conversion
        if (!power_en || (start_bit && state_r != ST_IDLE)) begin
            state_nxt     = ST_IDLE;
            phase_cnt_nxt = 4'h0;
            busy_nxt      = 1'b0;
        end
    end

    // start edge tracking
    always_comb begin
        start_seen_nxt = start_seen_r;
        if (start_bit) begin
            start_seen_nxt = 1'b1;
        end else if (start_seen_r) begin
            start_seen_nxt = 1'b0;
        end
    end

    // result capture only at conversion end
    // core code is taken as is: one step is reference over 4096, with no clamping applied
    assign result_nxt = conv_done ? core_code : result_r;

    // register writes
    assign ctrl0_nxt   = wr_ctrl0 ? {hwdata[7:4], 1'b0, hwdata[2:0]} : ctrl0_r;
    // bit 3 is unused and always stored as zero
    assign ctrl1_nxt   = wr_ctrl1 ? {hwdata[14:4], 1'b0, hwdata[2:0]}
                                  : ctrl1_r;
    assign irq_msk_nxt = wr_irq_msk ? hwdata[IRQ_DONE] : irq_msk_r;
    assign irq_glb_nxt = wr_irq_glb ? hwdata[IRQ_DONE] : irq_glb_r;
    // completion sets the flag; a set beats a one written to clear
    assign irq_st_nxt  = conv_done ? 1'b1
                         : (wr_irq_st && hwdata[IRQ_DONE]) ? 1'b0
                         : irq_st_r;

    // read mux, registered at the address phase
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_take) begin
            case (rd_addr)
                ADDR_CTRL0:   rdata_nxt = {24'h0, ctrl0_r[7:4], busy_r,
                                           ctrl0_r[2:0]};
                ADDR_CTRL1:   rdata_nxt = {17'h0, ctrl1_r};
                ADDR_RES_HI:  rdata_nxt = {24'h0, res_hi};
                ADDR_RES_LO:  rdata_nxt = {24'h0, res_lo};
                ADDR_IRQ_ST:  rdata_nxt = {31'h0, irq_st_r};
                ADDR_IRQ_MSK: rdata_nxt = {31'h0, irq_msk_r};
                ADDR_IRQ_GLB: rdata_nxt = {31'h0, irq_glb_r};
                default:      rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r   <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            wr_addr_r <= rd_addr;
            rdata_r   <= rdata_nxt;
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl0_r   <= CTRL0_RST;
            ctrl1_r   <= CTRL1_RST;
            irq_st_r  <= 1'b0;
            irq_msk_r <= 1'b0;
            irq_glb_r <= 1'b0;
        end else begin
            ctrl0_r   <= ctrl0_nxt;
            ctrl1_r   <= ctrl1_nxt;
            irq_st_r  <= irq_st_nxt;
            irq_msk_r <= irq_msk_nxt;
            irq_glb_r <= irq_glb_nxt;
        end
    end

    // sequencer state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r      <= ST_IDLE;
            phase_cnt_r  <= 4'h0;
            busy_r       <= 1'b0;
            start_seen_r <= 1'b0;
            result_r     <= 12'h000;
        end else begin
            state_r      <= state_nxt;
            phase_cnt_r  <= phase_cnt_nxt;
            busy_r       <= busy_nxt;
            start_seen_r <= start_seen_nxt;
            result_r     <= result_nxt;
        end
    end
endmodule : acs_sequencer

// file: hdl/acs_pkg.sv
package acs_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL0   = 8'h00;
    localparam logic [7:0] ADDR_CTRL1   = 8'h04;
    localparam logic [7:0] ADDR_RES_HI  = 8'h08;
    localparam logic [7:0] ADDR_RES_LO  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;
    localparam logic [7:0] ADDR_IRQ_GLB = 8'h18;
    // conv_control_0 fields
    localparam int C0_START   = 0;
    localparam int C0_POWER   = 1;
    localparam int C0_FORMAT  = 2;
    localparam int C0_BUSY    = 3;
    localparam int C0_CHAN_LO = 4;
    localparam int C0_CHAN_HI = 7;
    // conv_control_1 fields
    localparam int C1_DIV_LO  = 0;
    localparam int C1_DIV_HI  = 2;
    localparam int C1_SRC_LO  = 4;
    localparam int C1_SRC_HI  = 7;
    localparam int C1_REF_LO  = 8;
    localparam int C1_REF_HI  = 9;
    localparam int C1_GAIN_LO = 10;
    localparam int C1_GAIN_HI = 12;
    localparam int C1_PGA_LO  = 13;
    localparam int C1_PGA_HI  = 14;
    // interrupt bit positions
    localparam int IRQ_DONE   = 0;
    // reset values
    localparam logic [7:0]  CTRL0_RST = 8'h00;
    localparam logic [14:0] CTRL1_RST = 15'h0000;
    // conversion timing in conversion-clock cycles
    localparam int SAMPLE_CYCLES  = 4;
    localparam int CONVERT_CYCLES = 12;
    localparam int TOTAL_CYCLES   = SAMPLE_CYCLES + CONVERT_CYCLES;
    localparam logic [3:0] LAST_SAMPLE = 4'(SAMPLE_CYCLES - 1);
    localparam logic [3:0] LAST_CONV   = 4'(TOTAL_CYCLES - 1);
    // highest external channel number
    localparam logic [3:0] EXT_CHAN_MAX = 4'hB;
    localparam logic [11:0] FULL_SCALE  = 12'hFFF;
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_SAMPLE,
        ST_CONVERT
    } acs_state_type;
endpackage : acs_pkg

// file: hdl/acs_clk_div.sv
`timescale 1ns/1ps
// conversion clock enable: one tick every 2**div_sel system clocks
module acs_clk_div
    import acs_pkg::*;
#(
    parameter int SEL_W = 3,
    parameter int CNT_W = 7
) (
    input  wire logic             hclk,     // system clock
    input  wire logic             hresetn,  // async reset, low
    input  wire logic             run,      // count while high
    input  wire logic [SEL_W-1:0] div_sel,  // division code
    output logic                  tick      // conversion clock edge
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit;

    // terminal count per code: 0 gives no division, each code doubles
    assign limit   = CNT_W'((1 << div_sel) - 1);
    assign tick    = run && (cnt_r >= limit);
    assign cnt_nxt = (!run || tick) ? '0 : cnt_r + CNT_W'(1);

    // free counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : acs_clk_div

// file: test/acs_sequencer_chk.sv
`timescale 1ns/1ps
// watches conversion timing and channel routing at the top ports
module acs_sequencer_chk
    import acs_pkg::*;
(
    input wire logic       hclk,                // system clock
    input wire logic       hresetn,             // async reset, low
    input wire logic       hreadyout,           // slave ready
    input wire logic       hresp,               // response
    input wire logic       core_power_on,       // analog power
    input wire logic       core_sample,         // sampling phase
    input wire logic       core_convert,        // conversion phase
    input wire logic       core_conv_clk,       // conversion tick
    input wire logic       ext_channel_connect, // channel routed
    input wire logic [3:0] ext_channel_out,     // routed channel
    input wire logic [3:0] input_source_out,    // source code
    input wire logic       irq                  // interrupt
);
    logic [4:0] tick_cnt_r;
    logic       busy;
    logic       src_ext;
    // busy level and external source decode
    assign busy    = core_sample | core_convert;
    assign src_ext = input_source_out == 4'h0 || input_source_out == 4'h4 || input_source_out[3:2] == 2'b11;
    // ticks seen since the conversion began
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) tick_cnt_r <= 5'h00;
        else if (busy) tick_cnt_r <= tick_cnt_r + {4'h0, core_conv_clk};
        else tick_cnt_r <= 5'h00;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_ready: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered error");
    a_sample_len: assert property ($rose(core_convert) |-> tick_cnt_r == 5'h04 && $past(core_sample))
        else $error("sample phase not four ticks");
    a_total_len: assert property ($fell(core_convert) && core_power_on |-> tick_cnt_r == 5'h10)
        else $error("conversion not sixteen ticks");
    a_phase_excl: assert property (!(core_sample && core_convert))
        else $error("sample and convert overlap");
    a_tick_power: assert property (core_conv_clk |-> core_power_on)
        else $error("tick while powered off");
    a_off_idle: assert property (!core_power_on |-> !ext_channel_connect && (!busy || $past(core_power_on)))
        else $error("activity while powered off");
    a_int_discon: assert property (!src_ext |-> !ext_channel_connect && ext_channel_out == 4'h0)
        else $error("channel routed for internal source");
    a_sample_hold: assert property (core_sample && !core_conv_clk && core_power_on |=> core_sample)
        else $error("sample phase left without tick");
    a_conv_hold: assert property (core_convert && !core_conv_clk && core_power_on |=> core_convert)
        else $error("convert phase left without tick");
    c_done: cover property ($fell(core_convert));
    c_irq: cover property ($rose(irq));
    c_connect: cover property ($rose(ext_channel_connect));
endmodule : acs_sequencer_chk

// file: test/acs_sequencer_test.sv
`timescale 1ns/1ps
bind acs_sequencer acs_sequencer_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .core_power_on(core_power_on), .core_sample(core_sample), .core_convert(core_convert),
    .core_conv_clk(core_conv_clk), .ext_channel_connect(ext_channel_connect), .ext_channel_out(ext_channel_out),
    .input_source_out(input_source_out), .irq(irq));
module acs_sequencer_test;
    import acs_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout, irq;
    logic        rd_dp = 1'b0;
    logic        core_power_on, core_sample, core_convert, core_conv_clk, ext_channel_connect;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, reference_source_out, pga_input_out;
    logic [2:0]  hsize, pga_gain_out;
    logic [3:0]  ext_channel_out, input_source_out;
    logic [11:0] core_code;
    logic [31:0] exp_q[$];
    int          err_total = 0, num_checks = 0, cyc = 0, blen = 0, last_len = 0;
    acs_sequencer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_code(core_code), .core_power_on(core_power_on),
        .core_sample(core_sample), .core_convert(core_convert), .core_conv_clk(core_conv_clk),
        .ext_channel_connect(ext_channel_connect), .ext_channel_out(ext_channel_out),
        .input_source_out(input_source_out), .reference_source_out(reference_source_out),
        .pga_gain_out(pga_gain_out), .pga_input_out(pga_input_out), .irq(irq));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one single-word transfer, held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 3000 && (core_sample | core_convert) !== lvl; i++) @(posedge hclk);
    endtask : wait_busy
    function automatic logic [31:0] res(input logic [11:0] c, input logic f, input logic hi);
        logic [15:0] w;
        w = f ? {4'h0, c} : {c, 4'h0};
        return hi ? {24'h0, w[15:8]} : {24'h0, w[7:0]};
    endfunction : res
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // read data against oldest note, busy length, hang limit
    always @(posedge hclk) begin
        if (rd_dp) chk("hrdata", exp_q.pop_front(), hrdata);
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
        if (core_sample | core_convert) blen <= blen + 1;
        else if (blen != 0) begin
            last_len <= blen;
            blen <= 0;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        logic [11:0] code, prev;
        logic [3:0]  ch;
        logic [31:0] c0;
        logic        ext;
        {hsel, hwrite, htrans, haddr, hwdata, core_code} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        void'($urandom(32'h0C3D));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADDR_CTRL0, {24'h0, CTRL0_RST});
        rd(ADDR_CTRL1, {17'h0, CTRL1_RST});
        rd(8'h1C, 32'h0);
        // every source code, random channel, reference and gain
        for (int s = 0; s < 16; s++) begin
            c0 = $urandom;
            c0 = {17'h0, c0[14:8], s[3:0], 1'b0, c0[2:0]};
            ch = 4'($urandom_range(11));
            ext = s == 0 || s == 4 || s[3:2] == 2'b11;
            xfer(1'b1, ADDR_CTRL0, {24'h0, ch, 4'h2});
            xfer(1'b1, ADDR_CTRL1, c0);
            @(posedge hclk);
            chk("connect", {31'h0, ext}, {31'h0, ext_channel_connect});
            chk("channel", ext ? ch : 4'h0, ext_channel_out);
            chk("ref_pga", c0[14:8], {pga_input_out, pga_gain_out, reference_source_out});
        end
        prev = 12'h000;
        // one conversion per divider code
        for (int d = 0; d < 8; d++) begin
            code = (d == 7) ? FULL_SCALE : 12'($urandom);
            ch = 4'($urandom_range(11));
            core_code <= code;
            c0 = {24'h0, ch, 1'b0, d[0], 1'b1, 1'b0};
            xfer(1'b1, ADDR_IRQ_MSK, {31'h0, d[1]});
            xfer(1'b1, ADDR_IRQ_GLB, {31'h0, d[2]});
            xfer(1'b1, ADDR_CTRL1, {29'h0, d[2:0]});
            xfer(1'b1, ADDR_CTRL0, c0 | 32'h1);
            xfer(1'b1, ADDR_CTRL0, c0);
            wait_busy(1'b1);
            rd(ADDR_CTRL0, c0 | 32'h8);
            rd(ADDR_RES_HI, res(prev, d[0], 1'b1));
            wait_busy(1'b0);
            rd(ADDR_CTRL0, c0);
            rd(ADDR_RES_HI, res(code, d[0], 1'b1));
            rd(ADDR_RES_LO, res(code, d[0], 1'b0));
            rd(ADDR_IRQ_ST, 32'h1);
            chk("irq", d[1] & d[2], irq);
            chk("busy_len", TOTAL_CYCLES << d, last_len);
            xfer(1'b1, ADDR_IRQ_ST, 32'h1);
            @(posedge hclk);
            chk("irq_clear", 32'h0, irq);
            prev = code;
        end
        // power dropped mid conversion abandons it without a flag
        xfer(1'b1, ADDR_CTRL1, 32'h7);
        xfer(1'b1, ADDR_CTRL0, 32'h3);
        xfer(1'b1, ADDR_CTRL0, 32'h2);
        wait_busy(1'b1);
        xfer(1'b1, ADDR_CTRL0, 32'h0);
        repeat (2) @(posedge hclk);
        chk("abort_busy", 32'h0, {31'h0, core_sample | core_convert});
        rd(ADDR_IRQ_ST, 32'h0);
        // start pulse with power off is ignored
        xfer(1'b1, ADDR_CTRL1, 32'h0);
        xfer(1'b1, ADDR_CTRL0, 32'h1);
        xfer(1'b1, ADDR_CTRL0, 32'h0);
        repeat (20) @(posedge hclk);
        rd(ADDR_CTRL0, 32'h0);
        rd(ADDR_IRQ_ST, 32'h0);
        chk("power", 32'h0, core_power_on);
        @(posedge hclk);
        end_sim();
    end
endmodule : acs_sequencer_test
